// ---- rtl/insn_decode_pkg.sv ----
// Constants and types shared by the 14-bit instruction decoder
package insn_decode_pkg;

  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 14;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned BITN_W   = 3;
  localparam int unsigned LIT8_W   = 8;
  localparam int unsigned LIT11_W  = 11;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BITN_LSB = 7;
  localparam int unsigned GRP_MSB  = 13;
  localparam int unsigned GRP_LSB  = 12;

  // ----------------------------------------------------------------
  // Group codes in the top two bits
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;

  // Byte operation codes, bits 11:8
  localparam logic [3:0] BOP_MISC  = 4'h0;
  localparam logic [3:0] BOP_CLR   = 4'h1;
  localparam logic [3:0] BOP_DECSZ = 4'hB;
  localparam logic [3:0] BOP_INCSZ = 4'hF;

  // Control words under byte code zero
  localparam logic [6:0] CTL_RETURN = 7'h08;
  localparam logic [6:0] CTL_RETFIE = 7'h09;
  localparam logic [6:0] CTL_SLEEP  = 7'h63;
  localparam logic [6:0] CTL_CLRWDT = 7'h64;
  localparam logic [6:0] CTL_OPTION = 7'h62;
  localparam logic [6:0] CTL_DIRLOAD_LO = 7'h65;
  localparam logic [6:0] CTL_DIRLOAD_HI = 7'h67;

  // Bit operation codes, bits 11:10
  localparam logic [1:0] BTOP_SKIPCLR = 2'h2;
  localparam logic [1:0] BTOP_SKIPSET = 2'h3;

  // Literal codes, bits 11:10 (return-with-literal) and jump call bit 11
  localparam logic [1:0] LOP_RETLW = 2'h1;

  // Special file register addresses
  localparam logic [6:0] REG_TIMER0 = 7'h01;
  localparam logic [6:0] REG_PCLOW  = 7'h02;
  localparam logic [6:0] REG_PORTA  = 7'h05;
  localparam logic [6:0] REG_PORTG  = 7'h09;

  // ----------------------------------------------------------------
  // Instruction cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_LAST    = 2'(OSC_PER_CYCLE - 1);

  typedef enum logic [1:0] {
    CLASS_BYTE,
    CLASS_BIT,
    CLASS_LITCTL
  } insn_class_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_FLUSH
  } seq_state_t;

endpackage : insn_decode_pkg

// ---- rtl/fourteen_bit_instruction_decode.sv ----
// Decoder and cycle sequencer for 14-bit instruction words
//
// Function
// (RULE_01) Each instruction is one 14-bit word: operation field plus operand fields.
// (RULE_02) Every word falls in exactly one group: byte, bit, or literal/control.
// (RULE_03) Byte operation with destination 0 writes the accumulator only.
// (RULE_04) Byte operation with destination 1 writes back the addressed file register.
// (RULE_05) File address operand is seven bits, locations 0x00 to 0x7F.
// (RULE_06) Bit operations select one bit of the addressed 8-bit register.
// (RULE_07) Literal operand is eight or eleven bits depending on instruction.
// (RULE_08) Don't-care bits are ignored; behaviour is identical for 0 or 1.
// (RULE_09) Code generators should emit 0 in don't-care positions.
// (RULE_10) Instructions take one instruction cycle unless skipping or branching.
// (RULE_11) Skip taken or branch takes two cycles; second one is a no-op.
// (RULE_12) Each instruction cycle is four oscillator periods.
// (RULE_13) Software should avoid legacy option-load and tristate-load instructions.
// (RULE_14) Port read-modify-write takes operand from the pins, not the latch.
// (RULE_15) Writing the timer-zero register clears its prescaler when assigned.
// (RULE_16) Byte: 6 op, 1 dest, 7 addr; bit: 4 op, 3 bit, 7 addr.
// (RULE_17) Literal: 6 op plus 8 bits; call and jump: 3 op plus 11 bits.
`timescale 1ns/1ps

module fourteen_bit_instruction_decode (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  wire logic                                 insn_valid,
  input  wire logic [insn_decode_pkg::WORD_W-1:0]   insn_word,
  input  wire logic                                 cond_true,
  input  wire logic                                 prescaler_on_timer,
  output logic                                      insn_ready,
  output logic                                      phase_end,
  output logic                                      exec_valid,
  output logic                                      exec_is_nop,
  output insn_decode_pkg::insn_class_t              exec_class,
  output logic [5:0]                                exec_opcode,
  output logic [insn_decode_pkg::ADDR_W-1:0]        file_addr,
  output logic [insn_decode_pkg::BITN_W-1:0]        bit_sel,
  output logic [7:0]                                bit_mask,
  output logic [insn_decode_pkg::LIT11_W-1:0]       literal,
  output logic                                      literal_wide,
  output logic                                      write_accum,
  output logic                                      write_file,
  output logic                                      operand_from_pins,
  output logic                                      clear_prescaler,
  output logic                                      legacy_insn,
  output logic                                      changes_pc,
  output logic                                      cond_insn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    insn_decode_pkg::seq_state_t   st;
    logic [1:0]                    phase;
    logic                          insn_ready;
    logic                          phase_end;
    logic                          exec_valid;
    logic                          exec_is_nop;
    insn_decode_pkg::insn_class_t  exec_class;
    logic [5:0]                    exec_opcode;
    logic [6:0]                    file_addr;
    logic [2:0]                    bit_sel;
    logic [7:0]                    bit_mask;
    logic [10:0]                   literal;
    logic                          literal_wide;
    logic                          write_accum;
    logic                          write_file;
    logic                          operand_from_pins;
    logic                          clear_prescaler;
    logic                          legacy_insn;
    logic                          changes_pc;
    logic                          cond_insn;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Group from top bits; jump and literal both count as literal/control
  function automatic insn_decode_pkg::insn_class_t classify(input logic [13:0] w);
    logic [1:0] g;
    g = w[insn_decode_pkg::GRP_MSB:insn_decode_pkg::GRP_LSB];
    if (g == insn_decode_pkg::GRP_BYTE && w[11:8] == insn_decode_pkg::BOP_MISC &&
        !w[insn_decode_pkg::DEST_POS]) begin
      classify = insn_decode_pkg::CLASS_LITCTL;
    end else if (g == insn_decode_pkg::GRP_BYTE) begin
      classify = insn_decode_pkg::CLASS_BYTE;
    end else if (g == insn_decode_pkg::GRP_BIT) begin
      classify = insn_decode_pkg::CLASS_BIT;
    end else begin
      classify = insn_decode_pkg::CLASS_LITCTL;
    end
  endfunction : classify

  logic [1:0] grp;
  logic [6:0] low7;
  logic       is_byte;
  logic       is_bit;
  logic       is_ctl0;
  logic       is_port;
  logic       mod_file;
  logic       take_two;
  logic       skip_kind;
  logic       pc_kind;

  always_comb begin
    grp       = insn_word[insn_decode_pkg::GRP_MSB:insn_decode_pkg::GRP_LSB];
    low7      = insn_word[insn_decode_pkg::ADDR_LSB +: insn_decode_pkg::ADDR_W];
    is_byte   = classify(insn_word) == insn_decode_pkg::CLASS_BYTE;
    is_bit    = grp == insn_decode_pkg::GRP_BIT;
    is_ctl0   = grp == insn_decode_pkg::GRP_BYTE && !is_byte;
    is_port   = low7 >= insn_decode_pkg::REG_PORTA && low7 <= insn_decode_pkg::REG_PORTG;
    // Result goes back to the file: byte ops with dest set, bit clear and bit set
    mod_file  = (is_byte && insn_word[insn_decode_pkg::DEST_POS]) ||
                (is_bit && !insn_word[11]);
    skip_kind = (is_byte && (insn_word[11:8] == insn_decode_pkg::BOP_DECSZ ||
                             insn_word[11:8] == insn_decode_pkg::BOP_INCSZ)) ||
                (is_bit && (insn_word[11:10] == insn_decode_pkg::BTOP_SKIPCLR ||
                            insn_word[11:10] == insn_decode_pkg::BTOP_SKIPSET));
    pc_kind   = grp == insn_decode_pkg::GRP_JUMP ||
                (grp == insn_decode_pkg::GRP_LIT &&
                 insn_word[11:10] == insn_decode_pkg::LOP_RETLW) ||
                (is_ctl0 && (low7 == insn_decode_pkg::CTL_RETURN ||
                             low7 == insn_decode_pkg::CTL_RETFIE)) ||
                ((is_byte || is_bit) && low7 == insn_decode_pkg::REG_PCLOW && mod_file);
    take_two  = pc_kind || (skip_kind && cond_true); // RULE_10 RULE_11
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.phase_end  = 1'b0;
    s_d.exec_valid = 1'b0;
    s_d.insn_ready = 1'b0;
    s_d.phase      = (s_q.phase == insn_decode_pkg::PHASE_LAST) ? 2'h0 : s_q.phase + 2'h1; // RULE_12
    if (s_q.phase == insn_decode_pkg::PHASE_LAST) begin
      s_d.phase_end = 1'b1;
      case (s_q.st)
        insn_decode_pkg::ST_FLUSH: begin
          // Second cycle of a branch or taken skip does nothing
          s_d.exec_valid      = 1'b1; // RULE_11
          s_d.exec_is_nop     = 1'b1;
          s_d.write_accum     = 1'b0;
          s_d.write_file      = 1'b0;
          s_d.clear_prescaler = 1'b0;
          s_d.operand_from_pins = 1'b0;
          s_d.changes_pc      = 1'b0;
          s_d.st              = insn_decode_pkg::ST_IDLE;
        end
        default: begin
          if (insn_valid) begin
            s_d.exec_valid   = 1'b1;
            s_d.insn_ready   = 1'b1;
            s_d.exec_is_nop  = 1'b0;
            s_d.exec_class   = classify(insn_word); // RULE_01 RULE_02
            s_d.file_addr    = low7; // RULE_05
            s_d.bit_sel      = insn_word[insn_decode_pkg::BITN_LSB +: insn_decode_pkg::BITN_W]; // RULE_06
            s_d.bit_mask     = 8'h01 << insn_word[insn_decode_pkg::BITN_LSB +: insn_decode_pkg::BITN_W];
            s_d.literal_wide = grp == insn_decode_pkg::GRP_JUMP; // RULE_07
            if (grp == insn_decode_pkg::GRP_JUMP) begin
              s_d.exec_opcode = {3'h0, insn_word[13:11]}; // RULE_17
              s_d.literal     = insn_word[10:0];
            end else if (grp == insn_decode_pkg::GRP_LIT) begin
              s_d.exec_opcode = insn_word[13:8]; // RULE_17
              s_d.literal     = {3'h0, insn_word[7:0]};
            end else if (is_bit) begin
              s_d.exec_opcode = {2'h0, insn_word[13:10]}; // RULE_16
              s_d.literal     = 11'h000;
            end else begin
              s_d.exec_opcode = insn_word[13:8]; // RULE_16
              s_d.literal     = 11'h000;
            end
            s_d.write_file   = mod_file; // RULE_04
            s_d.write_accum  = (is_byte && !insn_word[insn_decode_pkg::DEST_POS] &&
                                insn_word[11:8] != insn_decode_pkg::BOP_MISC) ||
                               (grp == insn_decode_pkg::GRP_LIT &&
                                insn_word[11:10] != insn_decode_pkg::LOP_RETLW) ||
                               (grp == insn_decode_pkg::GRP_LIT &&
                                insn_word[11:10] == insn_decode_pkg::LOP_RETLW); // RULE_03
            s_d.operand_from_pins = mod_file && is_port; // RULE_14
            s_d.clear_prescaler   = mod_file && prescaler_on_timer &&
                                    low7 == insn_decode_pkg::REG_TIMER0; // RULE_15
            s_d.legacy_insn  = is_ctl0 && (low7 == insn_decode_pkg::CTL_OPTION ||
                                           (low7 >= insn_decode_pkg::CTL_DIRLOAD_LO &&
                                            low7 <= insn_decode_pkg::CTL_DIRLOAD_HI)); // RULE_13
            s_d.changes_pc   = pc_kind;
            s_d.cond_insn    = skip_kind;
            s_d.st           = take_two ? insn_decode_pkg::ST_FLUSH
                                        : insn_decode_pkg::ST_EXEC; // RULE_10
          end else begin
            s_d.exec_is_nop = 1'b1;
            s_d.write_accum = 1'b0;
            s_d.write_file  = 1'b0;
            s_d.clear_prescaler = 1'b0;
            // A pin operand flag must not outlive the write it qualifies
            s_d.operand_from_pins = 1'b0;
            s_d.st          = insn_decode_pkg::ST_IDLE;
          end
        end
      endcase
    end
    // Don't-care bits reach exec_opcode, file_addr and bit_sel unmasked, but none of the write, skip or branch terms above
    // RULE_08
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q             <= '0;
      s_q.st          <= insn_decode_pkg::ST_IDLE;
      s_q.exec_is_nop <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign insn_ready        = s_q.insn_ready;
  assign phase_end         = s_q.phase_end;
  assign exec_valid        = s_q.exec_valid;
  assign exec_is_nop       = s_q.exec_is_nop;
  assign exec_class        = s_q.exec_class;
  assign exec_opcode       = s_q.exec_opcode;
  assign file_addr         = s_q.file_addr;
  assign bit_sel           = s_q.bit_sel;
  assign bit_mask          = s_q.bit_mask;
  assign literal           = s_q.literal;
  assign literal_wide      = s_q.literal_wide;
  assign write_accum       = s_q.write_accum;
  assign write_file        = s_q.write_file;
  assign operand_from_pins = s_q.operand_from_pins;
  assign clear_prescaler   = s_q.clear_prescaler;
  assign legacy_insn       = s_q.legacy_insn;
  assign changes_pc        = s_q.changes_pc;
  assign cond_insn         = s_q.cond_insn;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_flush_cycle;
    !exec_valid [*3] ##1 (exec_valid && exec_is_nop);
  endsequence

  property p_phase_spacing;
    @(posedge clk) disable iff (rst) phase_end |=> !phase_end [*3] ##1 phase_end;
  endproperty
  a_phase_spacing: assert property (p_phase_spacing) else $error("cycle not four clocks"); // RULE_12

  property p_two_cycle;
    @(posedge clk) disable iff (rst)
      (exec_valid && !exec_is_nop && changes_pc) |=> s_flush_cycle;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("branch lacks nop cycle"); // RULE_11

  property p_skip_two;
    @(posedge clk) disable iff (rst)
      (exec_valid && !exec_is_nop && cond_insn && s_q.st == insn_decode_pkg::ST_FLUSH)
      |=> s_flush_cycle;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("taken skip lacks nop cycle"); // RULE_11

  property p_dest_exclusive;
    @(posedge clk) disable iff (rst)
      (exec_valid && exec_class == insn_decode_pkg::CLASS_BYTE) |-> !(write_accum && write_file);
  endproperty
  a_dest_exclusive: assert property (p_dest_exclusive) else $error("both destinations"); // RULE_03

  property p_dest_file;
    @(posedge clk) disable iff (rst)
      (insn_valid && phase_end == 1'b0 && s_q.phase == insn_decode_pkg::PHASE_LAST &&
       s_q.st != insn_decode_pkg::ST_FLUSH && is_byte && insn_word[7])
      |=> write_file;
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest one not to file"); // RULE_04

  property p_nop_quiet;
    @(posedge clk) disable iff (rst)
      (exec_valid && exec_is_nop) |-> !(write_file || write_accum || clear_prescaler);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop has side effects"); // RULE_11

  property p_mask;
    @(posedge clk) disable iff (rst) exec_valid |-> bit_mask == (8'h01 << bit_sel);
  endproperty
  a_mask: assert property (p_mask) else $error("bit mask mismatch"); // RULE_06

  property p_wide;
    @(posedge clk) disable iff (rst)
      (exec_valid && !exec_is_nop && !literal_wide) |-> literal[10:8] == 3'h0;
  endproperty
  a_wide: assert property (p_wide) else $error("narrow literal too wide"); // RULE_07

  property p_prescaler;
    @(posedge clk) disable iff (rst)
      clear_prescaler |-> write_file && file_addr == insn_decode_pkg::REG_TIMER0;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("stray prescaler clear"); // RULE_15

  property p_pins;
    @(posedge clk) disable iff (rst) operand_from_pins |-> write_file;
  endproperty
  a_pins: assert property (p_pins) else $error("pin operand without write"); // RULE_14

endmodule : fourteen_bit_instruction_decode

// ---- sim/prog_mem_model.sv ----
// Program memory model offering instruction words to the decoder
`timescale 1ns/1ps

module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        insn_ready,
  output logic             insn_valid,
  output logic [13:0]      insn_word,
  output logic             cond_true,
  output logic             prescaler_on_timer
);
  // Entry: prescaler flag, skip result, word; the two datapath levels
  // ride with the word so they stay fixed for as long as it is offered
  logic [15:0] q[$];
  logic [15:0] last;
  int          gap;

  initial begin
    insn_valid = 1'b0;
    {prescaler_on_timer, cond_true, insn_word} = 16'h0000;
    last = 16'h0000;
    gap = 0;
  end

  always @(posedge clk) begin
    if (rst) begin
      gap = 0;
      insn_valid <= 1'b0;
    end else begin
      if (insn_valid && insn_ready) begin
        void'(q.pop_front());
        gap = slow ? 5 : 0;
      end else if (gap != 0) begin
        gap = gap - 1;
      end
      if (q.size() != 0 && gap == 0) begin
        insn_valid <= 1'b1;
        {prescaler_on_timer, cond_true, insn_word} <= q[0];
        last = q[0];
      end else begin
        // A released bus must not look like the old word
        insn_valid <= 1'b0;
        {prescaler_on_timer, cond_true, insn_word} <= ~last;
      end
    end
  end
endmodule : prog_mem_model

// ---- sim/test_fourteen_bit_instruction_decode.sv ----
// Self-checking testbench for the 14-bit instruction decoder
`timescale 1ns/1ps

module test_fourteen_bit_instruction_decode;
  typedef struct packed {
    logic [1:0] cls; logic [6:0] addr; logic [2:0] bsel; logic [7:0] mask; logic [10:0] lit;
    logic [5:0] op;
    logic wide, wacc, wfile, pins, ck_pins, ck_lit, clrp, legacy, chpc, cond, two;
  } exp_t;

  logic        clk, rst, slow, insn_valid, cond_true, prescaler_on_timer;
  logic [13:0] insn_word;
  logic        insn_ready, phase_end, exec_valid, exec_is_nop, literal_wide;
  logic        write_accum, write_file, operand_from_pins, clear_prescaler;
  logic        legacy_insn, changes_pc, cond_insn;
  logic [5:0]  exec_opcode;
  logic [6:0]  file_addr;
  logic [2:0]  bit_sel;
  logic [7:0]  bit_mask;
  logic [10:0] literal;
  insn_decode_pkg::insn_class_t exec_class;
  int          mismatches, checks_done, seed, ph_cnt, ev_cnt;
  logic        pend_nop, had_next;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  exp_t        x;

  // ----------------------------------------------------------------
  // Corner words: {prescaler, skip result, word}; don't-care pairs in
  // zero form first, then with the spare bits set
  // ----------------------------------------------------------------
  localparam logic [15:0] CORNER [0:35] = '{
    16'h0785, 16'h0705, 16'h8081, 16'h8701, 16'h0A81, 16'h4B82, 16'h4F7F, 16'h0F00,
    16'h0100, 16'h017F, 16'h5B85, 16'h1C00, 16'h9581, 16'h1289, 16'h27FF, 16'h2923,
    16'h30A5, 16'h33A5, 16'h3E5A, 16'h3F5A, 16'h3400, 16'h77FF, 16'h3C01, 16'h3A80,
    16'h3800, 16'h39FF, 16'h0008, 16'h4009, 16'h0063, 16'h0064, 16'h0062, 16'h0065,
    16'h0066, 16'h0067, 16'h0000, 16'h0060};

  fourteen_bit_instruction_decode dut (
    .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
    .cond_true(cond_true), .prescaler_on_timer(prescaler_on_timer),
    .insn_ready(insn_ready), .phase_end(phase_end), .exec_valid(exec_valid),
    .exec_is_nop(exec_is_nop), .exec_class(exec_class), .exec_opcode(exec_opcode),
    .file_addr(file_addr), .bit_sel(bit_sel), .bit_mask(bit_mask), .literal(literal),
    .literal_wide(literal_wide), .write_accum(write_accum), .write_file(write_file),
    .operand_from_pins(operand_from_pins), .clear_prescaler(clear_prescaler),
    .legacy_insn(legacy_insn), .changes_pc(changes_pc), .cond_insn(cond_insn));

  prog_mem_model mem (
    .clk(clk), .rst(rst), .slow(slow), .insn_ready(insn_ready), .insn_valid(insn_valid),
    .insn_word(insn_word), .cond_true(cond_true), .prescaler_on_timer(prescaler_on_timer));

  // ----------------------------------------------------------------
  // Expectation and reporting
  // ----------------------------------------------------------------
  function automatic exp_t expect_of(input logic [15:0] en);
    exp_t        r;
    logic [13:0] w;
    logic [6:0]  a;
    logic [3:0]  op;
    w = en[13:0];
    a = w[6:0];
    op = w[11:8];
    r = '0;
    r.addr = a;
    r.op = w[13:8];
    r.bsel = w[9:7];
    r.mask = 8'h01 << w[9:7];
    r.pins = a >= insn_decode_pkg::REG_PORTA && a <= insn_decode_pkg::REG_PORTG;
    case (w[13:12])
      insn_decode_pkg::GRP_BYTE: begin
        if (op == insn_decode_pkg::BOP_MISC && !w[7]) begin
          r.cls = insn_decode_pkg::CLASS_LITCTL;
          r.chpc = a == insn_decode_pkg::CTL_RETURN || a == insn_decode_pkg::CTL_RETFIE;
          r.legacy = a == insn_decode_pkg::CTL_OPTION
                     || (a >= insn_decode_pkg::CTL_DIRLOAD_LO
                         && a <= insn_decode_pkg::CTL_DIRLOAD_HI);
        end else begin
          r.cls = insn_decode_pkg::CLASS_BYTE;
          r.wacc = !w[7];
          r.wfile = w[7];
          r.cond = op == insn_decode_pkg::BOP_DECSZ || op == insn_decode_pkg::BOP_INCSZ;
          r.chpc = w[7] && a == insn_decode_pkg::REG_PCLOW;
          r.clrp = w[7] && a == insn_decode_pkg::REG_TIMER0 && en[15];
          r.ck_pins = w[7] && op > insn_decode_pkg::BOP_CLR;
        end
      end
      insn_decode_pkg::GRP_BIT: begin
        r.cls = insn_decode_pkg::CLASS_BIT;
        r.op = {2'h0, w[13:10]};
        r.wfile = !w[11];
        r.cond = w[11];
        r.clrp = !w[11] && a == insn_decode_pkg::REG_TIMER0 && en[15];
        r.ck_pins = !w[11];
      end
      insn_decode_pkg::GRP_JUMP: begin
        r.cls = insn_decode_pkg::CLASS_LITCTL;
        r.lit = w[10:0];
        r.op = {3'h0, w[13:11]};
        r.wide = 1'b1;
        r.chpc = 1'b1;
        r.ck_lit = 1'b1;
      end
      default: begin
        r.cls = insn_decode_pkg::CLASS_LITCTL;
        r.lit = {3'h0, w[7:0]};
        r.wacc = 1'b1;
        r.chpc = w[11:10] == insn_decode_pkg::LOP_RETLW;
        r.ck_lit = 1'b1;
      end
    endcase
    r.two = r.chpc || (r.cond && en[14]);
    return r;
  endfunction : expect_of

  // Bit writes to the PC-low register are left open, so random words avoid them
  function automatic logic [15:0] rand_entry();
    logic [15:0] r;
    r = 16'($random(seed));
    if (r[13:12] == insn_decode_pkg::GRP_BIT && r[6:0] == insn_decode_pkg::REG_PCLOW) r[0] = 1'b1;
    return r;
  endfunction : rand_entry

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, want);
    end
  endtask : check

  task automatic push(input logic [15:0] en);
    mem.q.push_back(en);
    exp_q.push_back(en);
  endtask : push

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || pend_nop) && n < 8000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 8000) begin
      mismatches++;
      $display("[FAIL] %0t words left undecoded", $time);
    end
    repeat (8) @(posedge clk);
  endtask : drain

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Monitor, sampled on the falling edge where outputs have settled
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rst) begin
      ph_cnt = -1;
      ev_cnt = 0;
      pend_nop = 1'b0;
      had_next = 1'b0;
    end else begin
      ev_cnt++;
      if (ph_cnt >= 0) ph_cnt++;
      if (phase_end === 1'b1) begin
        if (ph_cnt >= 0) check(32'(ph_cnt), 32'd4, "phase spacing");
        ph_cnt = 0;
      end
      if (exec_valid === 1'b1) begin
        check(32'(phase_end), 32'd1, "valid off phase");
        if (pend_nop) begin
          check(32'(exec_is_nop), 32'd1, "second cycle not idle");
          check(32'(insn_ready), 32'd0, "word taken in flush");
          pend_nop = 1'b0;
        end else if (exp_q.size() == 0) begin
          check(32'(exec_is_nop), 32'd1, "decode without word");
        end else begin
          if (had_next && !slow) check(32'(ev_cnt), 32'd4, "single cycle");
          e = exp_q.pop_front();
          x = expect_of(e);
          check(32'(exec_is_nop), 32'd0, "idle flag");
          check(32'(insn_ready), 32'd1, "ready");
          check(32'(exec_class), 32'(x.cls), "class");
          check(32'(exec_opcode), 32'(x.op), "opcode");
          if (x.cls != insn_decode_pkg::CLASS_LITCTL) begin
            check(32'(file_addr), 32'(x.addr), "file address");
          end
          if (x.cls == insn_decode_pkg::CLASS_BIT) begin
            check(32'(bit_sel), 32'(x.bsel), "bit number");
            check(32'(bit_mask), 32'(x.mask), "bit mask");
          end
          check(32'(write_accum), 32'(x.wacc), "accumulator write");
          check(32'(write_file), 32'(x.wfile), "file write");
          if (x.ck_lit) check(32'(literal), 32'(x.lit), "literal");
          if (x.ck_lit) check(32'(literal_wide), 32'(x.wide), "literal width");
          if (x.ck_pins) check(32'(operand_from_pins), 32'(x.pins), "pin operand");
          check(32'(clear_prescaler), 32'(x.clrp), "prescaler clear");
          check(32'(legacy_insn), 32'(x.legacy), "legacy flag");
          check(32'(changes_pc), 32'(x.chpc), "branch flag");
          check(32'(cond_insn), 32'(x.cond), "skip flag");
          pend_nop = x.two;
        end
        had_next = exp_q.size() != 0;
        ev_cnt = 0;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    seed = 55566;
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    slow = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (CORNER[i]) push(CORNER[i]);
    drain();
    repeat (120) push(rand_entry());
    drain();
    // Slow supply: decoder must idle without inventing words
    slow <= 1'b1;
    repeat (30) push(rand_entry());
    drain();
    conclude();
  end
endmodule : test_fourteen_bit_instruction_decode
